// *** cpf_defines.svh ***
// Register offsets, flag positions and reset values of the flag datapath
`ifndef CPF_DEFINES_SVH
`define CPF_DEFINES_SVH

`define CPF_REG_FLAGS  4'h0
`define CPF_REG_IP_LO  4'h1
`define CPF_REG_IP_HI  4'h2
`define CPF_REG_STATUS 4'h3

`define CPF_BIT_V 7
`define CPF_BIT_H 4
`define CPF_BIT_I 3
`define CPF_BIT_N 2
`define CPF_BIT_Z 1
`define CPF_BIT_C 0

`define CPF_FLAGS_ONES 8'h60
`define CPF_FLAGS_RST  8'h68
`define CPF_IP_RST     16'h0000
`define CPF_VECT_HI    16'hfffe
`define CPF_VECT_LO    16'hffff

`endif

// *** cpf_pkg.sv ***
// Types of the instruction pointer, flag and addressing datapath
package cpf_pkg;

  typedef enum logic [3:0] {
    CMD_NONE   = 4'h0,
    CMD_FETCH  = 4'h1,
    CMD_NOMEM  = 4'h2,
    CMD_BRANCH = 4'h3,
    CMD_LIT8   = 4'h4,
    CMD_LIT16  = 4'h5,
    CMD_JUMP   = 4'h6,
    CMD_MOVE   = 4'h7,
    CMD_TESTBR = 4'h8,
    CMD_VECTOR = 4'h9
  } cpf_cmd_type;

  typedef enum logic [3:0] {
    ALU_ADD  = 4'h0,
    ALU_ADC  = 4'h1,
    ALU_SUB  = 4'h2,
    ALU_SBC  = 4'h3,
    ALU_BCD  = 4'h4,
    ALU_LD8  = 4'h5,
    ALU_LD16 = 4'h6,
    ALU_SHL  = 4'h7,
    ALU_SHR  = 4'h8,
    ALU_CLRI = 4'h9,
    ALU_SEI  = 4'ha,
    ALU_TAP  = 4'hb
  } cpf_alu_type;

  typedef enum logic [3:0] {
    COND_ALWAYS = 4'h0,
    COND_NEVER  = 4'h1,
    COND_EQ     = 4'h2,
    COND_NE     = 4'h3,
    COND_CS     = 4'h4,
    COND_CC     = 4'h5,
    COND_MI     = 4'h6,
    COND_PL     = 4'h7,
    COND_GE     = 4'h8,
    COND_LT     = 4'h9,
    COND_GT     = 4'ha,
    COND_LE     = 4'hb
  } cpf_cond_type;

  typedef enum logic [3:0] {
    ST_ISSUE = 4'h1,
    ST_WAIT  = 4'h2,
    ST_CAPT  = 4'h4,
    ST_IDLE  = 4'h8
  } cpf_state_type;

endpackage : cpf_pkg

// *** cpf_core.sv ***
// Instruction pointer, condition flags and operand addressing datapath
//
// Functional notes
// [RQ1] Keep 16-bit instruction pointer of next fetch
// [RQ2] Pointer advances by one per fetched byte
// [RQ3] Change-of-flow loads a non-sequential target
// [RQ4] Reset loads pointer from top vector pair
// [RQ5] Vector high byte from lower address
// [RQ6] Flags eight bits, bits six, five read one
// [RQ7] Bit seven is overflow; signed branches test it
// [RQ8] Bit four is half-carry from add
// [RQ9] Decimal adjust corrects using half-carry, carry
// [RQ10] Bit three masks maskable interrupts when set
// [RQ11] Mask set after stacking, before service code
// [RQ12] No interrupt right after mask is cleared
// [RQ13] Bit two follows result most significant bit
// [RQ14] Bit one set on all-zero result
// [RQ15] Bit zero is carry, borrow, shift, bit-test
// [RQ16] One linear 16-bit space for all accesses
// [RQ17] Move reads source, writes separate destination
// [RQ18] Test-branch fetches operand, then relative offset
// [RQ19] Register-only commands make no memory access
// [RQ20] Branch offset sign-extended, added when taken
// [RQ21] Inline operand follows opcode, high byte first
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "cpf_defines.svh"

module cpf_core (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdata,
  input  wire logic                 cmdValid,
  input  wire cpf_pkg::cpf_cmd_type cmdOp,
  input  wire cpf_pkg::cpf_cond_type cmdCond,
  input  wire logic [15:0]          cmdAddr,
  input  wire logic [15:0]          cmdDest,
  input  wire logic [2:0]           cmdBitSel,
  input  wire logic                 cmdBitPol,
  output logic                      cmdReady,
  output logic                      cmdDone,
  output logic      [15:0]          operand,
  input  wire logic                 aluStrobe,
  input  wire cpf_pkg::cpf_alu_type aluOp,
  input  wire logic [7:0]           aluA,
  input  wire logic [7:0]           aluB,
  output logic      [7:0]           aluResult,
  input  wire logic                 irqReq,
  input  wire logic                 stackDone,
  output logic                      irqTake,
  output logic      [15:0]          memAddr,
  output logic                      memRead,
  output logic                      memWrite,
  output logic      [7:0]           memWdata,
  input  wire logic [7:0]           memRdata,
  output logic      [15:0]          instructionPointer,
  output logic      [7:0]           conditionFlags
);

  cpf_pkg::cpf_state_type state, next_state;
  cpf_pkg::cpf_cmd_type   job, next_job;
  cpf_pkg::cpf_cond_type  cond, next_cond;
  logic [15:0] next_instructionPointer, next_operand, next_memAddr;
  logic [15:0] srcAddr, next_srcAddr, dstAddr, next_dstAddr;
  logic [15:0] branchTarget;
  logic [2:0]  bitSel, next_bitSel;
  logic        bitPol, next_bitPol, phase, next_phase;
  logic        testOk, next_testOk, next_memRead, next_memWrite;
  logic        next_cmdDone, condOk, testUpdate, testBit, fetchStart;
  logic [7:0]  hold, next_hold, next_memWdata;

  logic [7:0]  next_conditionFlags, next_aluResult, next_regRdata;
  logic [7:0]  corr, res;
  logic        irqInhibit, next_irqInhibit, cin, resFlags;
  logic [8:0]  sum, diff;
  logic [4:0]  lowSum;

  // Branch condition against the live flags
  always_comb begin
    case (cond)
      cpf_pkg::COND_ALWAYS: condOk = 1'b1;
      cpf_pkg::COND_NEVER:  condOk = 1'b0;
      cpf_pkg::COND_EQ:     condOk = conditionFlags[`CPF_BIT_Z];
      cpf_pkg::COND_NE:     condOk = !conditionFlags[`CPF_BIT_Z];
      cpf_pkg::COND_CS:     condOk = conditionFlags[`CPF_BIT_C];
      cpf_pkg::COND_CC:     condOk = !conditionFlags[`CPF_BIT_C];
      cpf_pkg::COND_MI:     condOk = conditionFlags[`CPF_BIT_N];
      cpf_pkg::COND_PL:     condOk = !conditionFlags[`CPF_BIT_N];
      cpf_pkg::COND_GE:     condOk = !(conditionFlags[`CPF_BIT_N] ^
                                       conditionFlags[`CPF_BIT_V]); // RQ7
      cpf_pkg::COND_LT:     condOk = conditionFlags[`CPF_BIT_N] ^
                                     conditionFlags[`CPF_BIT_V]; // RQ7
      cpf_pkg::COND_GT:     condOk = !(conditionFlags[`CPF_BIT_Z] |
                                       (conditionFlags[`CPF_BIT_N] ^
                                        conditionFlags[`CPF_BIT_V])); // RQ7
      cpf_pkg::COND_LE:     condOk = conditionFlags[`CPF_BIT_Z] |
                                     (conditionFlags[`CPF_BIT_N] ^
                                      conditionFlags[`CPF_BIT_V]); // RQ7
      default:              condOk = 1'b0;
    endcase
  end

  // Offset is taken from the byte being captured; pointer already past it
  assign branchTarget = instructionPointer +
                        {{8{memRdata[7]}}, memRdata}; // RQ20
  assign testBit      = memRdata[bitSel];
  assign cmdReady     = (state == cpf_pkg::ST_IDLE);
  assign fetchStart   = cmdReady && cmdValid &&
                        (cmdOp == cpf_pkg::CMD_FETCH);

  // Sequencer: every memory read is ISSUE, WAIT, CAPT; a move's write is issued from CAPT
  always_comb begin
    next_state              = state;
    next_job                = job;
    next_cond               = cond;
    next_instructionPointer = instructionPointer;
    next_srcAddr            = srcAddr;
    next_dstAddr            = dstAddr;
    next_bitSel             = bitSel;
    next_bitPol             = bitPol;
    next_phase              = phase;
    next_testOk             = testOk;
    next_hold               = hold;
    next_operand            = operand;
    next_memAddr            = memAddr;
    next_memRead            = 1'b0;
    next_memWrite           = 1'b0;
    next_memWdata           = memWdata;
    next_cmdDone            = 1'b0;
    testUpdate              = 1'b0;
    case (state)
      cpf_pkg::ST_IDLE: begin
        if (cmdValid) begin
          next_job     = cmdOp;
          next_cond    = cmdCond;
          next_srcAddr = cmdAddr;
          next_dstAddr = cmdDest;
          next_bitSel  = cmdBitSel;
          next_bitPol  = cmdBitPol;
          next_phase   = 1'b0;
          case (cmdOp)
            cpf_pkg::CMD_FETCH, cpf_pkg::CMD_BRANCH, cpf_pkg::CMD_LIT8,
            cpf_pkg::CMD_LIT16, cpf_pkg::CMD_MOVE,
            cpf_pkg::CMD_TESTBR: next_state = cpf_pkg::ST_ISSUE;
            cpf_pkg::CMD_JUMP: begin
              next_instructionPointer = cmdAddr; // RQ3
              next_cmdDone            = 1'b1;
            end
            cpf_pkg::CMD_NOMEM: next_cmdDone = 1'b1; // RQ19
            default: next_cmdDone = 1'b0;
          endcase
        end
      end
      cpf_pkg::ST_ISSUE: begin
        next_memRead = 1'b1; // RQ16
        next_state   = cpf_pkg::ST_WAIT;
        if (job == cpf_pkg::CMD_VECTOR) begin
          next_memAddr = phase ? `CPF_VECT_LO : `CPF_VECT_HI; // RQ4
        end else if (!phase && (job == cpf_pkg::CMD_MOVE ||
                                job == cpf_pkg::CMD_TESTBR)) begin
          next_memAddr = srcAddr; // RQ17 RQ18
        end else begin
          next_memAddr            = instructionPointer;
          next_instructionPointer = instructionPointer + 16'h0001; // RQ2
        end
      end
      cpf_pkg::ST_WAIT: next_state = cpf_pkg::ST_CAPT;
      cpf_pkg::ST_CAPT: begin
        next_hold    = memRdata;
        next_phase   = 1'b1;
        next_state   = cpf_pkg::ST_IDLE;
        next_cmdDone = 1'b1;
        case (job)
          cpf_pkg::CMD_VECTOR: begin
            next_cmdDone = 1'b0;
            if (!phase) begin
              next_state = cpf_pkg::ST_ISSUE;
            end else begin
              next_instructionPointer = {hold, memRdata}; // RQ4 RQ5
            end
          end
          cpf_pkg::CMD_FETCH, cpf_pkg::CMD_LIT8:
            next_operand = {8'h00, memRdata};
          cpf_pkg::CMD_LIT16: begin
            if (!phase) begin
              next_state   = cpf_pkg::ST_ISSUE;
              next_cmdDone = 1'b0;
            end else begin
              next_operand = {hold, memRdata}; // RQ21
            end
          end
          cpf_pkg::CMD_BRANCH: begin
            if (condOk) begin
              next_instructionPointer = branchTarget; // RQ3 RQ20
            end
          end
          cpf_pkg::CMD_MOVE: begin
            next_memAddr  = dstAddr; // RQ17
            next_memWrite = 1'b1;
            next_memWdata = memRdata;
          end
          cpf_pkg::CMD_TESTBR: begin
            if (!phase) begin
              testUpdate   = 1'b1; // RQ15
              next_testOk  = (testBit == bitPol); // RQ18
              next_operand = {8'h00, memRdata};
              next_state   = cpf_pkg::ST_ISSUE;
              next_cmdDone = 1'b0;
            end else if (testOk) begin
              next_instructionPointer = branchTarget; // RQ18 RQ20
            end
          end
          default: next_cmdDone = 1'b1;
        endcase
      end
      default: next_state = cpf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state              <= cpf_pkg::ST_ISSUE;
      job                <= cpf_pkg::CMD_VECTOR;
      cond               <= cpf_pkg::COND_ALWAYS;
      instructionPointer <= `CPF_IP_RST;
      srcAddr            <= 16'h0000;
      dstAddr            <= 16'h0000;
      bitSel             <= 3'h0;
      bitPol             <= 1'b0;
      phase              <= 1'b0;
      testOk             <= 1'b0;
      hold               <= 8'h00;
      operand            <= 16'h0000;
      memAddr            <= 16'h0000;
      memRead            <= 1'b0;
      memWrite           <= 1'b0;
      memWdata           <= 8'h00;
      cmdDone            <= 1'b0;
    end else begin
      state              <= next_state;
      job                <= next_job;
      cond               <= next_cond;
      instructionPointer <= next_instructionPointer; // RQ1
      srcAddr            <= next_srcAddr;
      dstAddr            <= next_dstAddr;
      bitSel             <= next_bitSel;
      bitPol             <= next_bitPol;
      phase              <= next_phase;
      testOk             <= next_testOk;
      hold               <= next_hold;
      operand            <= next_operand;
      memAddr            <= next_memAddr;
      memRead            <= next_memRead;
      memWrite           <= next_memWrite;
      memWdata           <= next_memWdata;
      cmdDone            <= next_cmdDone;
    end
  end

  // Flag update: ALU, bit test, software write, then stacking mask set
  always_comb begin
    next_conditionFlags = conditionFlags;
    next_aluResult      = aluResult;
    cin = ((aluOp == cpf_pkg::ALU_ADC) || (aluOp == cpf_pkg::ALU_SBC)) ?
          conditionFlags[`CPF_BIT_C] : 1'b0;
    sum    = {1'b0, aluA} + {1'b0, aluB} + {8'h00, cin};
    lowSum = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, cin};
    diff   = {1'b0, aluA} - {1'b0, aluB} - {8'h00, cin};
    corr   = 8'h00;
    if (conditionFlags[`CPF_BIT_H] || (aluA[3:0] > 4'h9)) begin
      corr[3:0] = 4'h6; // RQ9
    end
    if (conditionFlags[`CPF_BIT_C] || (aluA > 8'h99)) begin
      corr[7:4] = 4'h6; // RQ9
    end
    res      = aluA;
    resFlags = 1'b1;
    if (aluStrobe) begin
      case (aluOp)
        cpf_pkg::ALU_ADD, cpf_pkg::ALU_ADC: begin
          res = sum[7:0];
          next_conditionFlags[`CPF_BIT_C] = sum[8]; // RQ15
          next_conditionFlags[`CPF_BIT_H] = lowSum[4]; // RQ8
          next_conditionFlags[`CPF_BIT_V] = (aluA[7] == aluB[7]) &&
                                            (res[7] != aluA[7]); // RQ7
        end
        cpf_pkg::ALU_SUB, cpf_pkg::ALU_SBC: begin
          res = diff[7:0];
          next_conditionFlags[`CPF_BIT_C] = diff[8]; // RQ15
          next_conditionFlags[`CPF_BIT_V] = (aluA[7] != aluB[7]) &&
                                            (res[7] != aluA[7]); // RQ7
        end
        cpf_pkg::ALU_BCD: begin
          res = aluA + corr; // RQ9
          next_conditionFlags[`CPF_BIT_C] = (corr[7:4] != 4'h0);
        end
        cpf_pkg::ALU_LD8: begin
          res = aluB;
          next_conditionFlags[`CPF_BIT_V] = 1'b0;
        end
        cpf_pkg::ALU_LD16: begin
          res      = aluB;
          resFlags = 1'b0;
          next_conditionFlags[`CPF_BIT_V] = 1'b0;
          next_conditionFlags[`CPF_BIT_N] = aluA[7]; // RQ13
          next_conditionFlags[`CPF_BIT_Z] = ({aluA, aluB} == 16'h0000); // RQ14
        end
        cpf_pkg::ALU_SHL: begin
          res = {aluA[6:0], 1'b0};
          next_conditionFlags[`CPF_BIT_C] = aluA[7]; // RQ15
          next_conditionFlags[`CPF_BIT_V] = aluA[6] ^ aluA[7];
        end
        cpf_pkg::ALU_SHR: begin
          res = {1'b0, aluA[7:1]};
          next_conditionFlags[`CPF_BIT_C] = aluA[0]; // RQ15
          next_conditionFlags[`CPF_BIT_V] = aluA[0];
        end
        cpf_pkg::ALU_CLRI: begin
          resFlags = 1'b0;
          next_conditionFlags[`CPF_BIT_I] = 1'b0; // RQ10
        end
        cpf_pkg::ALU_SEI: begin
          resFlags = 1'b0;
          next_conditionFlags[`CPF_BIT_I] = 1'b1; // RQ10
        end
        cpf_pkg::ALU_TAP: begin
          resFlags            = 1'b0;
          next_conditionFlags = aluA;
        end
        default: resFlags = 1'b0;
      endcase
      if (resFlags) begin
        next_conditionFlags[`CPF_BIT_N] = res[7]; // RQ13
        next_conditionFlags[`CPF_BIT_Z] = (res == 8'h00); // RQ14
      end
      next_aluResult = res;
    end
    if (testUpdate) begin
      next_conditionFlags[`CPF_BIT_C] = testBit; // RQ15
    end
    if (regWrite && (regAddr == `CPF_REG_FLAGS)) begin
      next_conditionFlags = regWdata;
    end
    // Stacking done wins over any clear in the same cycle
    if (stackDone) begin
      next_conditionFlags[`CPF_BIT_I] = 1'b1; // RQ11
    end
    next_conditionFlags = next_conditionFlags | `CPF_FLAGS_ONES; // RQ6
    // A clear of the mask blocks interrupts until the next fetch command is accepted
    if (conditionFlags[`CPF_BIT_I] && !next_conditionFlags[`CPF_BIT_I]) begin
      next_irqInhibit = 1'b1; // RQ12
    end else if (fetchStart) begin
      next_irqInhibit = 1'b0;
    end else begin
      next_irqInhibit = irqInhibit;
    end
  end

  // Interrupts are only offered while the sequencer is idle between commands
  assign irqTake = cmdReady && irqReq && !conditionFlags[`CPF_BIT_I] &&
                   !irqInhibit; // RQ10 RQ12

  always_comb begin
    next_regRdata = 8'h00;
    if (regRead) begin
      case (regAddr)
        `CPF_REG_FLAGS:  next_regRdata = conditionFlags;
        `CPF_REG_IP_LO:  next_regRdata = instructionPointer[7:0];
        `CPF_REG_IP_HI:  next_regRdata = instructionPointer[15:8];
        `CPF_REG_STATUS: next_regRdata = {6'h00, irqInhibit, !cmdReady};
        default:         next_regRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      conditionFlags <= `CPF_FLAGS_RST;
      aluResult      <= 8'h00;
      irqInhibit     <= 1'b0;
      regRdata       <= 8'h00;
    end else begin
      conditionFlags <= next_conditionFlags;
      aluResult      <= next_aluResult;
      irqInhibit     <= next_irqInhibit;
      regRdata       <= next_regRdata;
    end
  end

endmodule : cpf_core

// *** cpf_core_monitor.sv ***
// Port checker of the pointer, flag and addressing datapath
`timescale 1ns/100ps
module cpf_core_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  cmdValid,
  input wire logic                  cmdReady,
  input wire cpf_pkg::cpf_cmd_type  cmdOp,
  input wire cpf_pkg::cpf_cond_type cmdCond,
  input wire logic [15:0]           cmdAddr,
  input wire logic                  cmdDone,
  input wire logic                  stackDone,
  input wire logic                  irqReq,
  input wire logic                  irqTake,
  input wire logic [15:0]           memAddr,
  input wire logic                  memRead,
  input wire logic                  memWrite,
  input wire logic [15:0]           instructionPointer,
  input wire logic [7:0]            conditionFlags
);
  logic take;
  assign take = cmdValid && cmdReady;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_ones; conditionFlags[6:5] == 2'b11; endproperty
  a_ones: assert property (p_ones)
    else $error("flag bits 6 and 5 not set");
  property p_vector;
    $rose(rst_n) |-> ##[0:3] (memRead && memAddr == 16'hfffe);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector fetch missing after reset");
  property p_fetch;
    take && cmdOp == cpf_pkg::CMD_FETCH |=> ##1 (memRead &&
      memAddr == $past(instructionPointer) &&
      instructionPointer == memAddr + 16'h0001) ##2 cmdDone;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch did not advance pointer by one");
  property p_jump;
    take && cmdOp == cpf_pkg::CMD_JUMP |=>
      (cmdDone && instructionPointer == $past(cmdAddr));
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");
  property p_noMem;
    take && cmdOp == cpf_pkg::CMD_NOMEM |=> (cmdDone && !memRead && !memWrite);
  endproperty
  a_noMem: assert property (p_noMem)
    else $error("register-only command touched memory");
  property p_brSkip;
    take && cmdOp == cpf_pkg::CMD_BRANCH && cmdCond == cpf_pkg::COND_NEVER
      |-> ##4 (cmdDone &&
      instructionPointer == $past(instructionPointer, 4) + 16'h0001);
  endproperty
  a_brSkip: assert property (p_brSkip)
    else $error("untaken branch moved pointer wrongly");
  property p_irq; irqTake |-> irqReq && cmdReady && !conditionFlags[3];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt taken while masked");
  property p_stack; stackDone |=> conditionFlags[3] && !irqTake; endproperty
  a_stack: assert property (p_stack)
    else $error("mask not set after stacking");
  property p_unmask; $fell(conditionFlags[3]) |-> !irqTake; endproperty
  a_unmask: assert property (p_unmask)
    else $error("interrupt taken right after unmask");

  c_move: cover property (take && cmdOp == cpf_pkg::CMD_MOVE);
  c_testBr: cover property (take && cmdOp == cpf_pkg::CMD_TESTBR);
  c_irq: cover property (irqTake);
endmodule : cpf_core_monitor

bind cpf_core cpf_core_monitor cpf_core_monitor_i (
  .ref_clk, .rst_n, .cmdValid, .cmdReady, .cmdOp, .cmdCond, .cmdAddr,
  .cmdDone, .stackDone, .irqReq, .irqTake, .memAddr, .memRead, .memWrite,
  .instructionPointer, .conditionFlags
);

// *** cpf_mem_model.sv ***
// Byte memory on the core's single 16-bit address space
`timescale 1ns/100ps
module cpf_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [7:0]  memWdata,
  output logic      [7:0]  memRdata
);
  logic [7:0] mem [0:65535];
  logic [1:0] holdCnt;
  initial begin
    memRdata = 8'h00;
    holdCnt  = 2'h0;
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
  end
  // Data holds three cycles, then toggles so a late sample shows up
  always @(posedge ref_clk) begin
    if (memWrite)
      mem[memAddr] <= memWdata;
    if (memRead) begin
      memRdata <= mem[memAddr];
      holdCnt  <= 2'h2;
    end else if (holdCnt != 2'h0)
      holdCnt <= holdCnt - 2'h1;
    else
      memRdata <= ~memRdata;
  end
endmodule : cpf_mem_model

// *** cpf_core_tb.sv ***
// Self-checking bench of the pointer, flag and addressing datapath
`timescale 1ns/100ps
module cpf_core_tb;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [3:0]            regAddr = 4'h0;
  logic [7:0]            regWdata = 8'h00;
  logic                  regWrite = 1'b0;
  logic                  regRead = 1'b0;
  logic                  cmdValid = 1'b0;
  cpf_pkg::cpf_cmd_type  cmdOp = cpf_pkg::CMD_NONE;
  cpf_pkg::cpf_cond_type cmdCond = cpf_pkg::COND_ALWAYS;
  logic [15:0]           cmdAddr = 16'h0000;
  logic [15:0]           cmdDest = 16'h0000;
  logic [2:0]            cmdBitSel = 3'h0;
  logic                  cmdBitPol = 1'b0;
  logic                  aluStrobe = 1'b0;
  cpf_pkg::cpf_alu_type  aluOp = cpf_pkg::ALU_ADD;
  logic [7:0]            aluA = 8'h00;
  logic [7:0]            aluB = 8'h00;
  logic                  irqReq = 1'b0;
  logic                  stackDone = 1'b0;
  logic                  cmdReady, cmdDone, irqTake, memRead, memWrite;
  logic [15:0]           operand, memAddr, instructionPointer;
  logic [7:0]            regRdata, aluResult, memWdata, memRdata;
  logic [7:0]            conditionFlags, rd;
  int                    num_errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  int                    n;

  always #50 ref_clk = ~ref_clk;

  cpf_core cpf_core_i (
    .ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .cmdValid, .cmdOp, .cmdCond, .cmdAddr, .cmdDest, .cmdBitSel, .cmdBitPol,
    .cmdReady, .cmdDone, .operand, .aluStrobe, .aluOp, .aluA, .aluB,
    .aluResult, .irqReq, .stackDone, .irqTake, .memAddr, .memRead,
    .memWrite, .memWdata, .memRdata, .instructionPointer, .conditionFlags
  );
  cpf_mem_model cpf_mem_model_i (
    .ref_clk, .memAddr, .memRead, .memWrite, .memWdata, .memRdata
  );

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic put(input logic [15:0] a, input logic [7:0] d);
    cpf_mem_model_i.mem[a] = d;
  endtask : put

  task automatic reg_rd(input logic [3:0] a);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    rd = regRdata;
  endtask : reg_rd

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : reg_wr

  task automatic run_cmd(input cpf_pkg::cpf_cmd_type op,
                         input logic [15:0] a,
                         input cpf_pkg::cpf_cond_type c);
    for (n = 0; n < 20 && cmdReady !== 1'b1; n++)
      @(negedge ref_clk);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdOp    <= op;
    cmdAddr  <= a;
    cmdCond  <= c;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    @(negedge ref_clk);
    for (n = 0; n < 20 && cmdDone !== 1'b1; n++)
      @(negedge ref_clk);
    chk("cmdDone", 16'h0001, {15'h0000, cmdDone});
  endtask : run_cmd

  task automatic alu(input cpf_pkg::cpf_alu_type op, input logic [7:0] a,
                     input logic [7:0] b, input logic [7:0] res,
                     input logic [7:0] mask, input logic [7:0] flg);
    @(posedge ref_clk);
    aluStrobe <= 1'b1;
    aluOp     <= op;
    aluA      <= a;
    aluB      <= b;
    @(posedge ref_clk);
    aluStrobe <= 1'b0;
    @(negedge ref_clk);
    chk("aluResult", {8'h00, res}, {8'h00, aluResult});
    reg_rd(4'h0);
    chk("aluFlags", {8'h00, flg}, {8'h00, rd & mask});
  endtask : alu

  // Hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    put(16'hfffe, 8'h12);
    put(16'hffff, 8'h34);
    put(16'h1234, 8'ha5);
    put(16'h1235, 8'hbe);
    put(16'h1236, 8'hef);
    put(16'h2000, 8'hfe);
    put(16'h1fff, 8'h10);
    put(16'h3000, 8'h5a);
    repeat (18) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 20 && cmdReady !== 1'b1; n++)
      @(negedge ref_clk);
    chk("ip", 16'h1234, instructionPointer);
    reg_rd(4'h0);
    chk("flagsReset", 16'h0068, {8'h00, rd});
    reg_rd(4'h1);
    chk("ipLow", 16'h0034, {8'h00, rd});
    reg_rd(4'h2);
    chk("ipHigh", 16'h0012, {8'h00, rd});
    reg_wr(4'h1, 8'h00);
    reg_rd(4'hf);
    chk("unmapped", 16'h0000, {8'h00, rd});
    reg_rd(4'h1);
    chk("ipLowKept", 16'h0034, {8'h00, rd});
    @(posedge ref_clk);
    irqReq <= 1'b1;
    reg_wr(4'h0, 8'h00);
    reg_rd(4'h0);
    chk("flagsOnes", 16'h0060, {8'h00, rd});
    chk("irqInhibit", 16'h0000, {15'h0000, irqTake});
    reg_rd(4'h3);
    chk("status", 16'h0002, {8'h00, rd});
    run_cmd(cpf_pkg::CMD_FETCH, 16'h0000, cpf_pkg::COND_ALWAYS);
    chk("fetchData", 16'h00a5, operand);
    chk("fetchIp", 16'h1235, instructionPointer);
    chk("irqTake", 16'h0001, {15'h0000, irqTake});
    @(posedge ref_clk);
    stackDone <= 1'b1;
    @(posedge ref_clk);
    stackDone <= 1'b0;
    irqReq    <= 1'b0;
    @(negedge ref_clk);
    chk("maskSet", 16'h0008, {8'h00, conditionFlags & 8'h08});
    run_cmd(cpf_pkg::CMD_LIT16, 16'h0000, cpf_pkg::COND_ALWAYS);
    chk("lit16", 16'hbeef, operand);
    chk("lit16Ip", 16'h1237, instructionPointer);
    run_cmd(cpf_pkg::CMD_NOMEM, 16'h0000, cpf_pkg::COND_ALWAYS);
    chk("noMemIp", 16'h1237, instructionPointer);
    run_cmd(cpf_pkg::CMD_JUMP, 16'h2000, cpf_pkg::COND_ALWAYS);
    chk("jumpIp", 16'h2000, instructionPointer);
    run_cmd(cpf_pkg::CMD_BRANCH, 16'h0000, cpf_pkg::COND_ALWAYS);
    chk("brBack", 16'h1fff, instructionPointer);
    run_cmd(cpf_pkg::CMD_BRANCH, 16'h0000, cpf_pkg::COND_NEVER);
    chk("brSkip", 16'h2000, instructionPointer);
    alu(cpf_pkg::ALU_SUB, 8'h80, 8'h01, 8'h7f, 8'h87, 8'h80);
    run_cmd(cpf_pkg::CMD_BRANCH, 16'h0000, cpf_pkg::COND_LT);
    chk("brSigned", 16'h1fff, instructionPointer);
    alu(cpf_pkg::ALU_ADD, 8'h08, 8'h08, 8'h10, 8'h10, 8'h10);
    alu(cpf_pkg::ALU_BCD, 8'h10, 8'h00, 8'h16, 8'h07, 8'h00);
    alu(cpf_pkg::ALU_ADD, 8'hff, 8'h01, 8'h00, 8'h03, 8'h03);
    alu(cpf_pkg::ALU_LD8, 8'h00, 8'h80, 8'h80, 8'h06, 8'h04);
    alu(cpf_pkg::ALU_SHL, 8'h81, 8'h00, 8'h02, 8'h01, 8'h01);
    alu(cpf_pkg::ALU_ADD, 8'h01, 8'h01, 8'h02, 8'h01, 8'h00);
    @(posedge ref_clk);
    cmdDest   <= 16'h3001;
    cmdBitSel <= 3'h1;
    cmdBitPol <= 1'b1;
    run_cmd(cpf_pkg::CMD_MOVE, 16'h3000, cpf_pkg::COND_ALWAYS);
    @(negedge ref_clk);
    chk("moved", 16'h005a, {8'h00, cpf_mem_model_i.mem[16'h3001]});
    run_cmd(cpf_pkg::CMD_TESTBR, 16'h3000, cpf_pkg::COND_ALWAYS);
    chk("testBrIp", 16'h2010, instructionPointer);
    chk("testBrC", 16'h0001, {15'h0000, conditionFlags[0]});
    stop_test();
  end
endmodule : cpf_core_tb
